// >>> hw/div_d_pkg.sv
// constants for the frame-pulse capable output divider d
package div_d_pkg;
  // ==========================================================
  // register map: one 24-bit register reached as three bytes
  localparam logic [7:0] ADDR_CFG_HI = 8'had; // bits 23:16
  localparam logic [7:0] ADDR_CFG_MID = 8'hae; // bits 15:8
  localparam logic [7:0] ADDR_CFG_LO = 8'haf; // bits 7:0
  localparam int CFG_W = 24;
  localparam logic [23:0] CFG_RESET = 24'h000000;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  // ==========================================================
  // field layout
  localparam int SHAPE_MSB = 23;
  localparam int SHAPE_LSB = 20;
  localparam logic [3:0] SHAPE_FRAME = 4'hf;
  localparam int TYPE_BIT = 19;
  localparam int POL_BIT = 18;
  localparam int SEL_MSB = 17;
  localparam int SEL_LSB = 16;
  localparam int PERIOD_MSB = 15;
  localparam int PERIOD_W = 16;
  // ==========================================================
  // related clock select codes
  localparam logic [1:0] SEL_DIV_A = 2'h0;
  localparam logic [1:0] SEL_DIV_B = 2'h1;
  localparam logic [1:0] SEL_DIV_C = 2'h2;
  // ==========================================================
  // regular clock limits
  localparam logic [23:0] MIN_RATIO = 24'h000002;
  localparam logic [23:0] MAX_RATIO = 24'hefffff; // software keeps ratio at or below
  // ==========================================================
  // output shape, one-hot
  typedef enum logic [1:0] {
    MODE_CLOCK = 2'b01,
    MODE_FRAME = 2'b10
  } mode_t;
endpackage : div_d_pkg

// >>> hw/half_duty_divider.sv
// divide-by-n clock generator with near 50% duty cycle
`timescale 1ns/1ps
module half_duty_divider #(
  parameter int W = 24
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic [W-1:0] i_ratio,
  output logic o_clk
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_clk;
  logic [W:0] ratio_sum;
  logic [W-1:0] half;

  // high for the first ceil(n/2) cycles; odd ratios are one cycle longer on the high side
  // because the divider only uses rising edges
  assign ratio_sum = {1'b0, i_ratio} + (W+1)'(1);
  assign half = ratio_sum[W:1];

  // ==========================================================
  // counter and output
  always_comb begin
    next_cnt = '1; // parked at the wrap point: the first enabled cycle starts a whole period
    next_clk = 1'b0;
    if (i_enable && (i_ratio >= W'(div_d_pkg::MIN_RATIO))) begin
      next_cnt = (cnt >= i_ratio - W'(1)) ? '0 : cnt + W'(1);
      next_clk = (next_cnt < half);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt <= '1;
      o_clk <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_clk <= next_clk;
    end
  end

  // ==========================================================
  // checking helpers: run lengths of the output, valid once the ratio held a whole period
  logic [W-1:0] hi_run;
  logic [W-1:0] per_run;
  logic settled;
  logic [W-1:0] ratio_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hi_run <= '0;
      per_run <= '0;
      settled <= 1'b0;
      ratio_q <= '0;
    end else begin
      ratio_q <= i_ratio;
      hi_run <= o_clk ? hi_run + W'(1) : '0;
      per_run <= (o_clk && !next_clk) ? per_run + W'(1) : ((!o_clk && next_clk) ? W'(1) : per_run + W'(1));
      if (!i_enable || (i_ratio != ratio_q)) begin
        settled <= 1'b0;
      end else if (!o_clk && next_clk) begin
        settled <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_div_period;
    settled && i_enable && !o_clk && next_clk && (i_ratio == ratio_q) |-> per_run == i_ratio;
  endproperty
  a_div_period: assert property (p_div_period) else $error("divider period differs from ratio");

  property p_div_duty;
    settled && i_enable && o_clk && !next_clk && (i_ratio == ratio_q) |-> hi_run + W'(1) == half;
  endproperty
  a_div_duty: assert property (p_div_duty) else $error("divider high time not half the period");
endmodule : half_duty_divider

// >>> hw/output_divider_d.sv
// output divider d: regular near 50% clock or frame pulse aligned to a sibling divider
// Overview of operation
// - shape field all ones selects frame-pulse output instead of a clock.
// - pulses are spaced by the period field, in related-clock periods.
// - select 00 picks divider a, 01 divider b, 10 divider c, 11 reserved.
// - each pulse lasts exactly one related-clock period for a period field of 2 or more; a period of 1 holds the pulse on.
// - polarity 0 gives a plain pulse, 1 an inverted pulse.
// - type 0 centres the pulse on the frame boundary, type 1 starts it there.
// - any other shape value with a ratio of 2 or more gives a regular clock with near 50% duty cycle, high one cycle longer for odd ratios.
// - regular clock divides the vco clock by the whole 24-bit register.
`timescale 1ns/1ps
module output_divider_d #(
  parameter int CFG_W = div_d_pkg::CFG_W,
  parameter int PERIOD_W = div_d_pkg::PERIOD_W
) (
  input wire logic i_clk_sys, // synthesizer vco clock
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_div_a, // sibling divider outputs, same vco clock
  input wire logic i_div_b,
  input wire logic i_div_c,
  output logic o_div_out
);
  // ==========================================================
  // configuration register
  logic [CFG_W-1:0] output_divider_d_config;
  logic [CFG_W-1:0] next_cfg;
  logic [7:0] next_rdata;

  // byte writes land at once; a ratio change over three writes passes through mixed values
  always_comb begin
    next_cfg = output_divider_d_config;
    if (i_reg_wr) begin
      case (i_reg_addr)
        div_d_pkg::ADDR_CFG_HI: next_cfg[23:16] = i_reg_wdata;
        div_d_pkg::ADDR_CFG_MID: next_cfg[15:8] = i_reg_wdata;
        div_d_pkg::ADDR_CFG_LO: next_cfg[7:0] = i_reg_wdata;
        default: next_cfg = output_divider_d_config;
      endcase
    end
    case (i_reg_addr)
      div_d_pkg::ADDR_CFG_HI: next_rdata = output_divider_d_config[23:16];
      div_d_pkg::ADDR_CFG_MID: next_rdata = output_divider_d_config[15:8];
      div_d_pkg::ADDR_CFG_LO: next_rdata = output_divider_d_config[7:0];
      default: next_rdata = div_d_pkg::RDATA_UNMAPPED;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      output_divider_d_config <= div_d_pkg::CFG_RESET;
      o_reg_rdata <= div_d_pkg::RDATA_UNMAPPED;
    end else begin
      output_divider_d_config <= next_cfg;
      o_reg_rdata <= next_rdata;
    end
  end

  // field views
  logic [3:0] shape;
  logic frame_type;
  logic frame_pol;
  logic [1:0] rel_sel;
  logic [PERIOD_W-1:0] period;
  assign shape = output_divider_d_config[div_d_pkg::SHAPE_MSB:div_d_pkg::SHAPE_LSB];
  assign frame_type = output_divider_d_config[div_d_pkg::TYPE_BIT];
  assign frame_pol = output_divider_d_config[div_d_pkg::POL_BIT];
  assign rel_sel = output_divider_d_config[div_d_pkg::SEL_MSB:div_d_pkg::SEL_LSB];
  assign period = output_divider_d_config[div_d_pkg::PERIOD_MSB:0];

  // ==========================================================
  // output shape state
  div_d_pkg::mode_t mode;
  div_d_pkg::mode_t next_mode;
  always_comb begin
    next_mode = (shape == div_d_pkg::SHAPE_FRAME) ? div_d_pkg::MODE_FRAME : div_d_pkg::MODE_CLOCK;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mode <= div_d_pkg::MODE_CLOCK;
    end else begin
      mode <= next_mode;
    end
  end

  // ==========================================================
  // related clock select and edge detect; siblings share the vco clock so no synchroniser
  logic rel_now;
  logic rel_prev;
  logic rel_rise;
  logic rel_fall;
  always_comb begin
    case (rel_sel)
      div_d_pkg::SEL_DIV_A: rel_now = i_div_a;
      div_d_pkg::SEL_DIV_B: rel_now = i_div_b;
      div_d_pkg::SEL_DIV_C: rel_now = i_div_c;
      default: rel_now = 1'b0; // reserved code: no edges, no pulses
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rel_prev <= 1'b0;
    end else begin
      rel_prev <= rel_now;
    end
  end
  assign rel_rise = rel_now && !rel_prev;
  assign rel_fall = !rel_now && rel_prev;

  // ==========================================================
  // frame pulse generator
  logic [PERIOD_W-1:0] cnt;
  logic [PERIOD_W-1:0] next_cnt;
  logic pulse;
  logic next_pulse;
  logic last_period;
  assign last_period = (cnt >= period - PERIOD_W'(1));

  always_comb begin
    next_cnt = cnt;
    next_pulse = pulse;
    if ((mode != div_d_pkg::MODE_FRAME) || (period == '0)) begin
      next_cnt = '0;
      next_pulse = 1'b0;
    end else begin
      if (rel_rise) begin
        next_cnt = last_period ? '0 : cnt + PERIOD_W'(1);
        if (frame_type) begin
          next_pulse = last_period; // boundary edge opens the pulse
        end
      end
      if (rel_fall && !frame_type) begin
        next_pulse = last_period; // straddles the boundary, mid to mid
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt <= '0;
      pulse <= 1'b0;
    end else begin
      cnt <= next_cnt;
      pulse <= next_pulse;
    end
  end

  // ==========================================================
  // regular clock divider and output select
  logic div_clk;
  logic next_out;
  half_duty_divider #(
    .W(CFG_W)
  ) u_div (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_enable(mode == div_d_pkg::MODE_CLOCK),
    .i_ratio(output_divider_d_config),
    .o_clk(div_clk)
  );

  always_comb begin
    next_out = (mode == div_d_pkg::MODE_FRAME) ? (pulse ^ frame_pol) : div_clk;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_div_out <= 1'b0;
    end else begin
      o_div_out <= next_out;
    end
  end

  // ==========================================================
  // checks; helper counts related rising edges seen while the pulse is high
  logic [PERIOD_W-1:0] rise_in_pulse;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rise_in_pulse <= '0;
    end else begin
      rise_in_pulse <= pulse ? rise_in_pulse + PERIOD_W'(rel_rise) : '0;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_shape_frame;
    shape == div_d_pkg::SHAPE_FRAME |=> mode == div_d_pkg::MODE_FRAME;
  endproperty
  a_shape_frame: assert property (p_shape_frame) else $error("frame shape not selected");

  property p_period_wrap;
    mode == div_d_pkg::MODE_FRAME && period > PERIOD_W'(1) && rel_rise && cnt == period - PERIOD_W'(1)
      && shape == div_d_pkg::SHAPE_FRAME |=> cnt == '0;
  endproperty
  a_period_wrap: assert property (p_period_wrap) else $error("frame counter did not wrap at period");

  property p_rel_select;
    rel_sel == div_d_pkg::SEL_DIV_B ##1 rel_sel == div_d_pkg::SEL_DIV_B |-> rel_prev == $past(i_div_b);
  endproperty
  a_rel_select: assert property (p_rel_select) else $error("related clock not divider b");

  property p_pulse_width;
    mode == div_d_pkg::MODE_FRAME && $stable(output_divider_d_config) && $fell(pulse) |-> $past(rise_in_pulse) == PERIOD_W'(1)
      || ($past(rise_in_pulse) == '0 && $past(rel_rise));
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("frame pulse not one related period");

  sequence s_frame_steady;
    mode == div_d_pkg::MODE_FRAME ##1 mode == div_d_pkg::MODE_FRAME;
  endsequence
  property p_polarity;
    s_frame_steady |-> o_div_out == ($past(pulse) ^ $past(frame_pol));
  endproperty
  a_polarity: assert property (p_polarity) else $error("frame pulse polarity wrong");

  property p_type_edge;
    $rose(pulse) && $past(mode == div_d_pkg::MODE_FRAME) |-> $past(frame_type ? rel_rise : rel_fall);
  endproperty
  a_type_edge: assert property (p_type_edge) else $error("pulse opened on wrong related edge");

  property p_clock_out;
    mode == div_d_pkg::MODE_CLOCK |=> o_div_out == $past(div_clk);
  endproperty
  a_clock_out: assert property (p_clock_out) else $error("clock mode output not the divider");

  property p_pulse_sync;
    $changed(pulse) && $past(mode == div_d_pkg::MODE_FRAME) && $past(period != '0) |-> $past(rel_rise || rel_fall);
  endproperty
  a_pulse_sync: assert property (p_pulse_sync) else $error("pulse moved off a related edge");
endmodule : output_divider_d

// >>> dv/output_divider_d_tb.sv
// self-checking testbench for output divider d
`timescale 1ns/1ps
module output_divider_d_tb;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wr = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] o_reg_rdata;
  logic i_div_a = 1'b0;
  logic i_div_b = 1'b0;
  logic i_div_c = 1'b0;
  logic o_div_out;
  int n_fail = 0;
  int cmp_count = 0;
  int sib_cnt = 0;

  // ==========================================================
  // clock and sibling dividers
  always #5 i_clk_sys = ~i_clk_sys;
  // sibling periods 8, 12, 16 cycles: half periods outlast the output latency
  always @(negedge i_clk_sys) begin
    sib_cnt <= (sib_cnt == 47) ? 0 : sib_cnt + 1;
    i_div_a <= (sib_cnt % 8) < 4;
    i_div_b <= (sib_cnt % 12) < 6;
    i_div_c <= (sib_cnt % 16) < 8;
  end

  output_divider_d u_output_divider_d (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata),
    .i_div_a(i_div_a),
    .i_div_b(i_div_b),
    .i_div_c(i_div_c),
    .o_div_out(o_div_out)
  );

  // ==========================================================
  // shared tasks
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  // one write strobe per byte, released a cycle later
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_clk_sys);
    i_reg_wr = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk_sys);
    i_reg_addr = a;
    @(negedge i_clk_sys);
    d = o_reg_rdata;
  endtask : reg_rd

  // high byte cleared first so no half-built frame setting is ever live
  task automatic cfg(input logic [23:0] v);
    reg_wr(div_d_pkg::ADDR_CFG_HI, 8'h00);
    reg_wr(div_d_pkg::ADDR_CFG_MID, v[15:8]);
    reg_wr(div_d_pkg::ADDR_CFG_LO, v[7:0]);
    reg_wr(div_d_pkg::ADDR_CFG_HI, v[23:16]);
  endtask : cfg

  // counts negedges while the output holds level v; a stuck output ends the run
  task automatic run_len(input logic v, input int bound, output int n);
    n = 0;
    while (o_div_out === v) begin
      n++;
      if (n > bound) begin
        n_fail++;
        $display("wrong value output level expected change seen stuck");
        summarize();
      end
      @(negedge i_clk_sys);
    end
  endtask : run_len

  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [7:0] d;
    reg_rd(div_d_pkg::ADDR_CFG_HI, d);
    chk("reset hi", d, 8'h00);
    reg_rd(div_d_pkg::ADDR_CFG_LO, d);
    chk("reset lo", d, 8'h00);
    reg_wr(div_d_pkg::ADDR_CFG_HI, 8'h12);
    reg_wr(div_d_pkg::ADDR_CFG_MID, 8'h34);
    reg_wr(div_d_pkg::ADDR_CFG_LO, 8'h56);
    reg_wr(8'hb0, 8'hff);
    reg_rd(div_d_pkg::ADDR_CFG_HI, d);
    chk("cfg hi", d, 8'h12);
    reg_rd(div_d_pkg::ADDR_CFG_MID, d);
    chk("cfg mid", d, 8'h34);
    reg_rd(div_d_pkg::ADDR_CFG_LO, d);
    chk("cfg lo", d, 8'h56);
    reg_rd(8'hb0, d);
    chk("unmapped", d, 8'h00);
    $display("test registers done");
  endtask : t_regs

  task automatic t_clock();
    logic [23:0] r [3] = '{24'h000006, 24'h000007, 24'h000103};
    int hi;
    int lo;
    foreach (r[i]) begin
      cfg(r[i]);
      @(negedge i_clk_sys);
      run_len(1'b1, 300, hi);
      run_len(1'b0, 300, lo);
      run_len(1'b1, 300, hi);
      run_len(1'b0, 300, lo);
      chk("clock high", hi, (r[i] + 1) / 2);
      chk("clock low", lo, r[i] / 2);
    end
    $display("test clock mode done");
  endtask : t_clock

  task automatic t_frame();
    int per;
    int w;
    int gap;
    logic [1:0] sel;
    logic pol;
    logic typ;
    logic rel;
    for (int k = 0; k < 6; k++) begin
      sel = 2'(k % 3);
      pol = 1'(k / 3);
      typ = 1'(k % 2);
      per = 8 + 4 * (k % 3);
      cfg({div_d_pkg::SHAPE_FRAME, typ, pol, sel, 16'h0003});
      // two edges drain the last clock-mode level; the first pulse is at least one and a half related periods away
      repeat (2) @(negedge i_clk_sys);
      chk("idle level", o_div_out, pol);
      run_len(pol, 200, gap);
      run_len(~pol, 200, w);
      run_len(pol, 200, gap);
      rel = (sel == div_d_pkg::SEL_DIV_A) ? i_div_a : (sel == div_d_pkg::SEL_DIV_B) ? i_div_b : i_div_c;
      run_len(~pol, 200, w);
      run_len(pol, 200, gap);
      chk("pulse width", w, per);
      chk("pulse spacing", w + gap, 3 * per);
      chk("related level at pulse start", rel, typ);
    end
    $display("test frame pulse done");
  endtask : t_frame

  // settings that must leave the output parked at one level
  task automatic t_quiet();
    logic [23:0] c [3] = '{24'h000001, 24'hf00000, 24'hf70003};
    logic e [3] = '{1'b0, 1'b0, 1'b1};
    int n;
    foreach (c[i]) begin
      cfg(c[i]);
      repeat (5) @(negedge i_clk_sys);
      n = 0;
      repeat (60) begin
        @(negedge i_clk_sys);
        n += (o_div_out !== e[i]);
      end
      chk("parked output", n, 0);
    end
    $display("test parked output done");
  endtask : t_quiet

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(negedge i_clk_sys);
    i_rst = 1'b0;
    t_regs();
    t_clock();
    t_frame();
    t_quiet();
    summarize();
  end
endmodule : output_divider_d_tb
